// [core/acc_pkg.sv]
package acc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Printed offsets are not all multiples of four: they are word indices.
    localparam logic [7:0]  ACC_IDX_CONV_CTRL_B   = 8'h03;
    localparam logic [7:0]  ACC_IDX_CMP_CTRL      = 8'h08;
    localparam logic [7:0]  ACC_IDX_DIG_IN_DIS    = 8'h14;
    localparam logic [7:0]  ACC_IDX_CONV_STATE    = 8'h20;
    localparam logic [7:0]  ACC_IDX_IRQ_STATUS    = 8'h21;
    localparam logic [7:0]  ACC_IDX_IRQ_MASK      = 8'h22;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ACC_B_MUX_EN       = 6;
    localparam int ACC_B_CMP_DISABLE  = 7;
    localparam int ACC_B_BANDGAP      = 6;
    localparam int ACC_B_RESULT       = 5;
    localparam int ACC_B_FLAG         = 4;
    localparam int ACC_B_IRQ_EN       = 3;
    localparam int ACC_B_RESERVED     = 2;
    localparam int ACC_B_NEG_DIS      = 1;
    localparam int ACC_B_POS_DIS      = 0;
    localparam int ACC_B_CONV_EN      = 0;
    localparam int ACC_B_GIE          = 1;

    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACC_CONV_B_WMASK      = 8'he7;
    localparam logic [7:0]  ACC_DIG_IN_WMASK      = 8'h3f;
    localparam logic [7:0]  ACC_CONV_STATE_WMASK  = 8'h03;
    localparam logic [7:0]  ACC_REG_RESET         = 8'h00;
    localparam logic [1:0]  ACC_STS_RESET         = 2'h0;

    // Interrupt status bits: comparator event and result change.
    localparam int ACC_S_EVENT  = 0;
    localparam int ACC_S_CHANGE = 1;

    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE   = 2'b00,
        ACC_MODE_RESERVED = 2'b01,
        ACC_MODE_FALL     = 2'b10,
        ACC_MODE_RISE     = 2'b11
    } acc_mode_t;

endpackage : acc_pkg

// [core/acc_edge_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface acc_edge_if;
    logic       result;
    logic       rise;
    logic       fall;
    modport src (output result, output rise, output fall);
    modport dst (input result, input rise, input fall);
endinterface : acc_edge_if
`default_nettype wire

// [core/acc_sync_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_sync_edge (
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Raw comparator level
    input  wire logic   raw_in,
    // Synchronised level and edges
    acc_edge_if.src     edge_o
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
        end
    end

    // Edges compare against the value one clock earlier.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    assign edge_o.result = sync_ff;
    assign edge_o.rise   = sync_ff & ~prev_ff;
    assign edge_o.fall   = ~sync_ff & prev_ff;
endmodule : acc_sync_edge
`default_nettype wire

// [core/acc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Analog comparator front end
    input  wire logic         cmp_raw_out,
    output logic              cmp_power_on,
    output logic              cmp_pos_use_bandgap,
    output logic              cmp_neg_use_channel,
    output logic [1:0]        cmp_neg_channel,
    // Channel select from the converter multiplexer
    input  wire logic [1:0]   channel_select_low,
    // Pin buffers
    input  wire logic         cmp_positive_pin,
    input  wire logic         cmp_negative_pin,
    output logic              pos_pin_buffer_on,
    output logic              neg_pin_buffer_on,
    output logic              pos_pin_value,
    output logic              neg_pin_value,
    // Processor interrupt
    input  wire logic         irq_ack,
    output logic              cmp_irq_req,
    output logic              irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] conv_b_ff;
    logic [7:0] dig_dis_ff;
    logic       cmp_disable_ff;
    logic       bandgap_select_ff;
    logic       cmp_irq_flag_ff;
    logic       cmp_irq_enable_ff;
    logic [1:0] cmp_irq_mode_ff;
    logic       converter_enable_ff;
    logic       global_irq_enable_ff;
    logic [1:0] sts_ff;
    logic [1:0] mask_ff;
    logic [1:0] pin_meta_ff;
    logic [1:0] pin_sync_ff;
    logic [7:0] prdata_ff;
    logic [1:0] nxt_sts;
    logic       nxt_flag;
    logic       cmp_event;
    logic [7:0] cmp_ctrl_view;
    logic [7:0] rd_mux;
    logic       wr_acc;
    logic       rd_acc;
    logic       addr_ok;
    logic [7:0] idx;
    logic [7:0] wbyte;

    acc_edge_if edge_bus ();

    acc_sync_edge u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .raw_in  (cmp_raw_out),
        .edge_o  (edge_bus.src)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    function automatic logic idx_known(input logic [7:0] i);
        idx_known = (i == ACC_IDX_CONV_CTRL_B) || (i == ACC_IDX_CMP_CTRL) ||
                    (i == ACC_IDX_DIG_IN_DIS) || (i == ACC_IDX_CONV_STATE) ||
                    (i == ACC_IDX_IRQ_STATUS) || (i == ACC_IDX_IRQ_MASK);
    endfunction : idx_known

    // Write-one-to-clear helper; a set in the same cycle wins.
    function automatic logic w1c(input logic cur, input logic set, input logic clr);
        w1c = set | (cur & ~clr);
    endfunction : w1c

    assign idx     = paddr[9:2];
    assign addr_ok = idx_known(idx) && (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign wr_acc  = psel & penable & pwrite & addr_ok & pstrb[0];
    assign rd_acc  = psel & ~penable & ~pwrite;
    assign wbyte   = pwdata[7:0];
    assign pready  = 1'b1;
    // Unmapped or misaligned addresses answer with an error.
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = {24'h000000, prdata_ff};

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_b_ff  <= ACC_REG_RESET;
            dig_dis_ff <= ACC_REG_RESET;
        end else if (wr_acc && idx == ACC_IDX_CONV_CTRL_B) begin
            conv_b_ff  <= wbyte & ACC_CONV_B_WMASK;
        end else if (wr_acc && idx == ACC_IDX_DIG_IN_DIS) begin
            dig_dis_ff <= wbyte & ACC_DIG_IN_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_disable_ff    <= 1'b0;
            bandgap_select_ff <= 1'b0;
            cmp_irq_enable_ff <= 1'b0;
            cmp_irq_mode_ff   <= 2'h0;
        end else if (wr_acc && idx == ACC_IDX_CMP_CTRL) begin
            cmp_disable_ff    <= wbyte[ACC_B_CMP_DISABLE];
            bandgap_select_ff <= wbyte[ACC_B_BANDGAP];
            cmp_irq_enable_ff <= wbyte[ACC_B_IRQ_EN];
            cmp_irq_mode_ff   <= wbyte[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_enable_ff  <= 1'b0;
            global_irq_enable_ff <= 1'b0;
        end else if (wr_acc && idx == ACC_IDX_CONV_STATE) begin
            converter_enable_ff  <= wbyte[ACC_B_CONV_EN];
            global_irq_enable_ff <= wbyte[ACC_B_GIE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= ACC_STS_RESET;
        end else if (wr_acc && idx == ACC_IDX_IRQ_MASK) begin
            mask_ff <= wbyte[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Analog routing
    // ------------------------------------------------------------------
    // The channel pins belong to the converter whenever it is powered.
    assign cmp_neg_use_channel = conv_b_ff[ACC_B_MUX_EN] & ~converter_enable_ff;
    assign cmp_neg_channel     = channel_select_low;
    assign cmp_pos_use_bandgap = bandgap_select_ff;
    assign cmp_power_on        = ~cmp_disable_ff;

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    // The reserved mode never fires, so stray writes cannot raise requests.
    always_comb begin
        case (acc_mode_t'(cmp_irq_mode_ff))
            ACC_MODE_TOGGLE: cmp_event = edge_bus.rise | edge_bus.fall;
            ACC_MODE_FALL:   cmp_event = edge_bus.fall;
            ACC_MODE_RISE:   cmp_event = edge_bus.rise;
            default:         cmp_event = 1'b0;
        endcase
    end

    always_comb begin
        nxt_flag = cmp_event | (cmp_irq_flag_ff & ~irq_ack);
        if (wr_acc && idx == ACC_IDX_CMP_CTRL && wbyte[ACC_B_FLAG]) begin
            nxt_flag = cmp_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_irq_flag_ff <= 1'b0;
        end else begin
            cmp_irq_flag_ff <= nxt_flag;
        end
    end

    assign cmp_irq_req = cmp_irq_flag_ff & cmp_irq_enable_ff & global_irq_enable_ff;

    // ------------------------------------------------------------------
    // Sticky status and interrupt line
    // ------------------------------------------------------------------
    always_comb begin
        logic [1:0] clr;
        clr = 2'h0;
        if (wr_acc && idx == ACC_IDX_IRQ_STATUS) begin
            clr = wbyte[1:0];
        end
        nxt_sts[ACC_S_EVENT]  = w1c(sts_ff[ACC_S_EVENT], cmp_event, clr[ACC_S_EVENT]);
        nxt_sts[ACC_S_CHANGE] = w1c(sts_ff[ACC_S_CHANGE], edge_bus.rise | edge_bus.fall,
                                    clr[ACC_S_CHANGE]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_ff <= ACC_STS_RESET;
        end else begin
            sts_ff <= nxt_sts;
        end
    end

    assign irq = |(sts_ff & mask_ff);

    // ------------------------------------------------------------------
    // Pin digital inputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= 2'h0;
            pin_sync_ff <= 2'h0;
        end else begin
            pin_meta_ff <= {cmp_negative_pin, cmp_positive_pin};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign pos_pin_buffer_on = ~dig_dis_ff[ACC_B_POS_DIS];
    assign neg_pin_buffer_on = ~dig_dis_ff[ACC_B_NEG_DIS];
    assign pos_pin_value     = pin_sync_ff[0] & ~dig_dis_ff[ACC_B_POS_DIS];
    assign neg_pin_value     = pin_sync_ff[1] & ~dig_dis_ff[ACC_B_NEG_DIS];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        cmp_ctrl_view                    = 8'h00;
        cmp_ctrl_view[ACC_B_CMP_DISABLE] = cmp_disable_ff;
        cmp_ctrl_view[ACC_B_BANDGAP]     = bandgap_select_ff;
        cmp_ctrl_view[ACC_B_RESULT]      = edge_bus.result;
        cmp_ctrl_view[ACC_B_FLAG]        = cmp_irq_flag_ff;
        cmp_ctrl_view[ACC_B_IRQ_EN]      = cmp_irq_enable_ff;
        cmp_ctrl_view[1:0]               = cmp_irq_mode_ff;
        case (idx)
            ACC_IDX_CONV_CTRL_B: rd_mux = conv_b_ff;
            ACC_IDX_CMP_CTRL:    rd_mux = cmp_ctrl_view;
            ACC_IDX_DIG_IN_DIS:  rd_mux = dig_dis_ff;
            ACC_IDX_CONV_STATE:  rd_mux = {6'h00, global_irq_enable_ff, converter_enable_ff};
            ACC_IDX_IRQ_STATUS:  rd_mux = {6'h00, sts_ff};
            ACC_IDX_IRQ_MASK:    rd_mux = {6'h00, mask_ff};
            default:             rd_mux = 8'h00;
        endcase
    end

    // Read data is captured in setup so it is stable through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 8'h00;
        end else if (rd_acc) begin
            prdata_ff <= rd_mux;
        end
    end

endmodule : acc_ctrl
`default_nettype wire

// [test/acc_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model #(
    parameter logic [7:0]      BANDGAP_LVL = 8'h78,
    parameter logic [7:0]      NEG_LVL     = 8'h32,
    parameter logic [3:0][7:0] CH_LVL      = {8'hb4, 8'h1e, 8'hc8, 8'h14}
) (
    // Controls from the block
    input  wire logic       cmp_power_on,
    input  wire logic       cmp_pos_use_bandgap,
    input  wire logic       cmp_neg_use_channel,
    input  wire logic [1:0] cmp_neg_channel,
    // Level on the positive pin
    input  wire logic [7:0] pos_lvl,
    // Comparator output
    output logic            cmp_raw_out
);
    logic [7:0] p_lvl;
    logic [7:0] n_lvl;
    assign p_lvl = cmp_pos_use_bandgap ? BANDGAP_LVL : pos_lvl;
    assign n_lvl = cmp_neg_use_channel ? CH_LVL[cmp_neg_channel] : NEG_LVL;
    // A stage without power has no valid output; holding it low keeps it quiet.
    assign cmp_raw_out = cmp_power_on && (p_lvl > n_lvl);
endmodule : acc_analog_model
`default_nettype wire

// [test/acc_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Comparator and pins
    input wire logic        cmp_raw_out,
    input wire logic        cmp_power_on,
    input wire logic        pos_pin_buffer_on,
    input wire logic        neg_pin_buffer_on,
    input wire logic        pos_pin_value,
    input wire logic        neg_pin_value,
    // Interrupts
    input wire logic        irq_ack,
    input wire logic        cmp_irq_req,
    input wire logic        irq
);
    // ----------
    // History
    // ----------
    logic [3:0] raw_ff;
    logic       wr_ff;
    logic       ctl_wr_ff;
    logic       cause;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_ff    <= 4'h0;
            wr_ff     <= 1'b0;
            ctl_wr_ff <= 1'b0;
        end else begin
            raw_ff    <= {raw_ff[2:0], cmp_raw_out};
            wr_ff     <= psel && penable && pwrite;
            ctl_wr_ff <= psel && penable && pwrite && paddr == 12'h020;
        end
    end
    // A raw change reaches a flag three edges later, a write at once.
    assign cause = wr_ff || (raw_ff[2] ^ raw_ff[3]);
    // ----------
    // Checks
    // ----------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_ack_quiet;
        irq_ack && cmp_irq_req && !(raw_ff[1] ^ raw_ff[2]);
    endsequence
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_bad_align: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    chk_pos_off: assert property (!pos_pin_buffer_on |-> !pos_pin_value)
        else $error("positive pin value not forced low");
    chk_neg_off: assert property (!neg_pin_buffer_on |-> !neg_pin_value)
        else $error("negative pin value not forced low");
    chk_ack_clear: assert property (s_ack_quiet |=> !cmp_irq_req)
        else $error("acknowledge did not clear request");
    chk_req_cause: assert property ($rose(cmp_irq_req) |-> cause)
        else $error("request rose without cause");
    chk_irq_cause: assert property ($rose(irq) |-> cause)
        else $error("irq rose without cause");
    chk_power_write: assert property ($changed(cmp_power_on) |-> ctl_wr_ff)
        else $error("power changed without control write");
endmodule : acc_ctrl_monitor
bind acc_ctrl acc_ctrl_monitor u_mon (.*);
`default_nettype wire

// [test/tb_analog_comparator_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_analog_comparator_control
    import acc_pkg::*;
;
    localparam logic [11:0] A_CVB = {2'h0, ACC_IDX_CONV_CTRL_B, 2'h0};
    localparam logic [11:0] A_CMP = {2'h0, ACC_IDX_CMP_CTRL, 2'h0};
    localparam logic [11:0] A_DIS = {2'h0, ACC_IDX_DIG_IN_DIS, 2'h0};
    localparam logic [11:0] A_CST = {2'h0, ACC_IDX_CONV_STATE, 2'h0};
    localparam logic [11:0] A_STS = {2'h0, ACC_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] A_MSK = {2'h0, ACC_IDX_IRQ_MASK, 2'h0};
    // Row: bandgap, mux enable, converter on, channel, use channel, result.
    localparam logic [6:0]  ROWS [8] = '{7'h23, 7'h26, 7'h2b, 7'h2e, 7'h35, 7'h6e, 7'h45, 7'h01};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        irq_ack = 1'b0, cmp_positive_pin = 1'b0, cmp_negative_pin = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [1:0]  channel_select_low = 2'h0;
    logic [7:0]  pos_lvl = 8'h00;
    logic        pready, pslverr, cmp_raw_out, cmp_power_on, cmp_pos_use_bandgap, cmp_neg_use_channel;
    logic        pos_pin_buffer_on, neg_pin_buffer_on, pos_pin_value, neg_pin_value, cmp_irq_req, irq;
    logic [31:0] prdata;
    logic [1:0]  cmp_neg_channel;
    logic [7:0]  rdv;
    logic [6:0]  r;
    logic        errv;
    int          error_cnt = 0;
    int          n_compared = 0;
    acc_ctrl         dut (.*);
    acc_analog_model u_ana (.*);
    always #20 pclk = ~pclk;
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic finish_test;
        $display("Compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            error_cnt++;
            finish_test();
        end
        rdv = prdata[7:0];
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        cyc(20);
        presetn <= 1'b1;
        pos_lvl <= 8'h50;
        chk("power_on", cmp_power_on, 8'h01);
        chk("irq_req", cmp_irq_req, 8'h00);
        chk("irq", irq, 8'h00);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            channel_select_low <= r[3:2];
            apb(1'b1, A_CVB, {1'b0, r[5], 6'h1f});
            apb(1'b1, A_CST, {7'h00, r[4]});
            apb(1'b1, A_CMP, {1'b0, r[6], 6'h00});
            cyc(4);
            apb(1'b0, A_CVB, 8'h00);
            chk("conv_ctrl_b", rdv, {1'b0, r[5], 6'h07});
            chk("use_channel", cmp_neg_use_channel, {7'h00, r[1]});
            chk("neg_channel", cmp_neg_channel, {6'h00, r[3:2]});
            chk("use_bandgap", cmp_pos_use_bandgap, {7'h00, r[6]});
            apb(1'b0, A_CMP, 8'h00);
            chk("result", rdv[ACC_B_RESULT], {7'h00, r[0]});
        end
        // Interrupt enable stays low around power and mode changes.
        apb(1'b1, A_CMP, 8'h84);
        cyc(4);
        chk("power_off", cmp_power_on, 8'h00);
        apb(1'b0, A_CMP, 8'h00);
        chk("ctrl_off", rdv & 8'hef, 8'h80);
        apb(1'b1, A_CMP, 8'h00);
        pos_lvl <= 8'h10;
        apb(1'b1, A_CMP, 8'h03);
        cyc(4);
        apb(1'b1, A_CMP, 8'h13);
        apb(1'b1, A_CST, 8'h02);
        apb(1'b1, A_CMP, 8'h0b);
        cyc(1);
        chk("req_idle", cmp_irq_req, 8'h00);
        pos_lvl <= 8'h50;
        cyc(4);
        chk("req_rise", cmp_irq_req, 8'h01);
        apb(1'b0, A_CMP, 8'h00);
        chk("ctrl_rise", rdv, 8'h3b);
        irq_ack <= 1'b1;
        cyc(1);
        irq_ack <= 1'b0;
        cyc(1);
        chk("req_ack", cmp_irq_req, 8'h00);
        pos_lvl <= 8'h10;
        cyc(4);
        chk("req_fall", cmp_irq_req, 8'h00);
        apb(1'b1, A_CMP, 8'h03);
        apb(1'b1, A_CMP, 8'h02);
        pos_lvl <= 8'h50;
        cyc(4);
        pos_lvl <= 8'h10;
        cyc(4);
        apb(1'b1, A_CMP, 8'h02);
        apb(1'b0, A_CMP, 8'h00);
        chk("flag_keep", rdv, 8'h12);
        apb(1'b1, A_CMP, 8'h12);
        apb(1'b0, A_CMP, 8'h00);
        chk("flag_clear", rdv, 8'h02);
        apb(1'b1, A_CMP, 8'h01);
        pos_lvl <= 8'h50;
        cyc(4);
        pos_lvl <= 8'h10;
        cyc(4);
        apb(1'b0, A_CMP, 8'h00);
        chk("reserved", rdv, 8'h01);
        apb(1'b1, A_MSK, 8'h02);
        cyc(1);
        chk("irq_on", irq, 8'h01);
        apb(1'b1, A_STS, 8'h03);
        cyc(1);
        chk("irq_off", irq, 8'h00);
        apb(1'b0, A_STS, 8'h00);
        chk("status", rdv, 8'h00);
        apb(1'b1, A_DIS, 8'hff);
        cmp_positive_pin <= 1'b1;
        cmp_negative_pin <= 1'b1;
        cyc(3);
        chk("pos_buf", pos_pin_buffer_on, 8'h00);
        chk("pos_val", pos_pin_value, 8'h00);
        chk("neg_val", neg_pin_value, 8'h00);
        apb(1'b0, A_DIS, 8'h00);
        chk("dig_dis", rdv, 8'h3f);
        apb(1'b1, A_DIS, 8'h00);
        cyc(1);
        chk("pos_val_on", pos_pin_value, 8'h01);
        chk("neg_val_on", neg_pin_value, 8'h01);
        apb(1'b1, 12'h3fc, 8'h00);
        chk("slverr_map", errv, 8'h01);
        apb(1'b0, 12'h021, 8'h00);
        chk("slverr_align", errv, 8'h01);
        apb(1'b1, A_CMP, 8'h00);
        apb(1'b1, A_CMP, 8'h08);
        presetn <= 1'b0;
        cyc(2);
        chk("rst_out", cmp_irq_req | irq, 8'h00);
        presetn <= 1'b1;
        apb(1'b0, A_CMP, 8'h00);
        chk("rst_ctrl", rdv & 8'hdf, 8'h00);
        chk("rst_power", cmp_power_on, 8'h01);
        finish_test();
    end
endmodule : tb_analog_comparator_control
`default_nettype wire
